// File: hdl/dteu_top.sv
`timescale 1ns/10ps
`include "dteu_cfg.svh"
module dteu_top (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [1:0]  ext_count_pin_i,
  output logic             irq_o,
  output logic             wake_o
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // register index of a counter register kind, 0 high 1 low 2 control
  function automatic logic [5:0] dteu_idx(input int ch, input int kind);
    logic [5:0] base;
    base = (ch == 0) ? `DTEU_IDX_C0_HI : `DTEU_IDX_C1_HI;
    return base + 6'(kind);
  endfunction

  // true when an index addresses the given counter register
  function automatic logic dteu_hit(input logic [5:0] idx,
                                    input int ch, input int kind);
    return idx == dteu_idx(ch, kind);
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************

  logic              req;
  logic              ack;
  logic              first;
  dteu_pkg::dteu_acc_t acc;

  assign req   = avs_read_i | avs_write_i;
  assign first = req & ~ack;

  // one wait cycle per access, answer on the second edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= first;
    end
  end

  assign avs_waitrequest_o = req & ~ack;

  // side effects happen once, on the first edge of an access
  always_comb begin
    acc.wr   = first & avs_write_i & avs_byteenable_i[0];
    acc.rd   = first & avs_read_i;
    acc.idx  = avs_address_i[7:2];
    acc.data = avs_writedata_i[7:0];
  end

  // ****************************************************************
  // divide by four prescaler
  // ****************************************************************

  logic [1:0] pre_cnt;
  logic       tick;

  // instruction clock enable, one pulse every four system clocks
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pre_cnt <= 2'h0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end

  assign tick = (pre_cnt == `DTEU_PRESCALE);

  // ****************************************************************
  // interrupt control register
  // ****************************************************************

  logic [1:0] ovf;
  logic [1:0] ovf_flag;
  logic [1:0] ovf_irq_en;
  logic       wr_irq;

  assign wr_irq = acc.wr & (acc.idx == `DTEU_IDX_IRQ);

  // enable bits written by software
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ovf_irq_en <= 2'(`DTEU_IRQ_RESET >> `DTEU_IRQ_EN0);
    end else if (wr_irq) begin
      ovf_irq_en <= {acc.data[`DTEU_IRQ_EN1], acc.data[`DTEU_IRQ_EN0]};
    end
  end

  // sticky overflow flags, a new overflow wins over a clear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ovf_flag <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ovf[i]) begin
          ovf_flag[i] <= 1'b1;
        end else if (wr_irq) begin
          ovf_flag[i] <= acc.data[`DTEU_IRQ_FLAG0 + i];
        end
      end
    end
  end

  // interrupt request gated by per counter enable
  assign irq_o = |(ovf_flag & ovf_irq_en);

  // wake pulse on any overflow
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= |ovf;
    end
  end

  // ****************************************************************
  // counters
  // ****************************************************************

  logic [15:0]          count   [2];
  logic [15:0]          preload [2];
  logic [7:0]           low_buf [2];
  logic [1:0]           run;
  dteu_pkg::dteu_ctrl_t ctrl    [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_cnt
      logic                     lvl;
      logic                     lvl_d;
      logic                     rise;
      logic                     fall;
      logic                     act_edge;
      logic                     ret_edge;
      logic                     hold;
      logic                     inc;
      logic                     pw_end;
      logic                     wr_hi;
      logic                     wr_lo;
      logic                     wr_ct;
      logic                     rd_hi;
      dteu_pkg::dteu_pw_state_t pw_state;

      dteu_pin_sync u_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .pin_i   (ext_count_pin_i[g]),
        .level_o (lvl)
      );

      // delayed pin level for edge detection
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          lvl_d <= 1'b0;
        end else begin
          lvl_d <= lvl;
        end
      end

      assign rise     = lvl & ~lvl_d;
      assign fall     = ~lvl & lvl_d;
      assign act_edge = ctrl[g].edge_select ? fall : rise;
      assign ret_edge = ctrl[g].edge_select ? rise : fall;

      // register strobes of this counter
      assign wr_hi = acc.wr & dteu_hit(acc.idx, g, 0);
      assign wr_lo = acc.wr & dteu_hit(acc.idx, g, 1);
      assign wr_ct = acc.wr & dteu_hit(acc.idx, g, 2);
      assign rd_hi = acc.rd & dteu_hit(acc.idx, g, 0);

      // count clock blocked for the whole high byte read
      assign hold = avs_read_i & dteu_hit(acc.idx, g, 0);

      // count enable per mode
      always_comb begin
        inc = 1'b0;
        if (run[g] && !hold) begin
          case (ctrl[g].mode)
            dteu_pkg::DTEU_MODE_EVENT: inc = act_edge;
            dteu_pkg::DTEU_MODE_TIMER: inc = tick;
            dteu_pkg::DTEU_MODE_PULSE:
              inc = tick & (pw_state == dteu_pkg::DTEU_PW_MEAS);
            default: inc = 1'b0;
          endcase
        end
      end

      assign ovf[g]  = inc & (count[g] == `DTEU_COUNT_MAX);
      assign pw_end  = run[g] & (ctrl[g].mode == dteu_pkg::DTEU_MODE_PULSE)
                       & (pw_state == dteu_pkg::DTEU_PW_MEAS) & ret_edge;

      // control fields written by software
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          ctrl[g] <= dteu_pkg::dteu_ctrl_t'({2'h0, 1'b1});
        end else if (wr_ct) begin
          ctrl[g].mode        <= dteu_pkg::dteu_mode_t'(
            {acc.data[`DTEU_CTL_MODE_HI], acc.data[`DTEU_CTL_MODE_LO]});
          ctrl[g].edge_select <= acc.data[`DTEU_CTL_EDGE];
        end
      end

      // run bit, cleared by hardware only at end of a measurement
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          run[g] <= 1'b0;
        end else if (wr_ct) begin
          run[g] <= acc.data[`DTEU_CTL_RUN];
        end else if (pw_end) begin
          run[g] <= 1'b0;
        end
      end

      // pulse width measurement sequence
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          pw_state <= dteu_pkg::DTEU_PW_WAIT;
        end else begin
          case (pw_state)
            dteu_pkg::DTEU_PW_WAIT: begin
              if (run[g] && act_edge &&
                  ctrl[g].mode == dteu_pkg::DTEU_MODE_PULSE) begin
                pw_state <= dteu_pkg::DTEU_PW_MEAS;
              end
            end
            dteu_pkg::DTEU_PW_MEAS: begin
              if (pw_end) begin
                pw_state <= dteu_pkg::DTEU_PW_DONE;
              end else if (!run[g]) begin
                pw_state <= dteu_pkg::DTEU_PW_WAIT;
              end
            end
            dteu_pkg::DTEU_PW_DONE: begin
              if (run[g]) begin
                pw_state <= dteu_pkg::DTEU_PW_WAIT;
              end
            end
            default: pw_state <= dteu_pkg::DTEU_PW_WAIT;
          endcase
        end
      end

      // low byte holding buffer
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          low_buf[g] <= 8'h00;
        end else if (wr_lo) begin
          low_buf[g] <= acc.data;
        end else if (rd_hi) begin
          low_buf[g] <= count[g][7:0];
        end
      end

      // preload loaded only from a high byte write
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          preload[g] <= 16'h0000;
        end else if (wr_hi) begin
          preload[g] <= {acc.data, low_buf[g]};
        end
      end

      // counter proper
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          count[g] <= 16'h0000;
        end else if (wr_hi && !run[g]) begin
          count[g] <= {acc.data, low_buf[g]};
        end else if (ovf[g]) begin
          count[g] <= preload[g];
        end else if (inc) begin
          count[g] <= count[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read data
  // ****************************************************************

  logic [7:0] rd_byte;

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (dteu_hit(acc.idx, i, 0)) begin
        rd_byte = count[i][15:8];
      end else if (dteu_hit(acc.idx, i, 1)) begin
        rd_byte = low_buf[i];
      end else if (dteu_hit(acc.idx, i, 2)) begin
        rd_byte = {ctrl[i].mode, 1'b0, run[i],
                   ctrl[i].edge_select, 3'h0};
      end
    end
    if (acc.idx == `DTEU_IDX_IRQ) begin
      rd_byte = {1'b0, ovf_flag, 1'b0, ovf_irq_en, 2'h0};
    end
  end

  // read data registered on the first edge of a read
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (acc.rd) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule

// File: hdl/dteu_cfg.svh
`ifndef DTEU_CFG_SVH
`define DTEU_CFG_SVH

// register indices, byte address is four times the index
`define DTEU_IDX_IRQ      6'h0B
`define DTEU_IDX_C0_HI    6'h0C
`define DTEU_IDX_C0_LO    6'h0D
`define DTEU_IDX_C0_CTL   6'h0E
`define DTEU_IDX_C1_HI    6'h0F
`define DTEU_IDX_C1_LO    6'h10
`define DTEU_IDX_C1_CTL   6'h11

// control register field positions
`define DTEU_CTL_EDGE     3
`define DTEU_CTL_RUN      4
`define DTEU_CTL_MODE_LO  6
`define DTEU_CTL_MODE_HI  7

// interrupt control register field positions
`define DTEU_IRQ_EN0      2
`define DTEU_IRQ_EN1      3
`define DTEU_IRQ_FLAG0    5
`define DTEU_IRQ_FLAG1    6

// reset values
`define DTEU_CTL_RESET    8'h08
`define DTEU_IRQ_RESET    8'h00

// counting figures
`define DTEU_PRESCALE     2'h3
`define DTEU_COUNT_MAX    16'hFFFF

`endif

// File: hdl/dteu_pkg.sv
package dteu_pkg;

  // operating mode field values
  typedef enum logic [1:0] {
    DTEU_MODE_NONE  = 2'h0,
    DTEU_MODE_EVENT = 2'h1,
    DTEU_MODE_TIMER = 2'h2,
    DTEU_MODE_PULSE = 2'h3
  } dteu_mode_t;

  // pulse width measurement progress, one-hot
  typedef enum logic [2:0] {
    DTEU_PW_WAIT = 3'h1,
    DTEU_PW_MEAS = 3'h2,
    DTEU_PW_DONE = 3'h4
  } dteu_pw_state_t;

  // stored control fields of one counter
  typedef struct packed {
    dteu_mode_t mode;
    logic       edge_select;
  } dteu_ctrl_t;

  // decoded bus access of one cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] idx;
    logic [7:0] data;
  } dteu_acc_t;

endpackage

// File: hdl/dteu_pin_sync.sv
`timescale 1ns/10ps
module dteu_pin_sync (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1;
  logic s2;
  logic s3;

  // three stage synchroniser, first stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // level changes once the second and third stage agree
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end

endmodule

// File: verif/dteu_top_props.sv
`timescale 1ns/10ps
`include "dteu_cfg.svh"
// ****
// bus and counter checker
// ****
module dteu_top_props (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  ext_count_pin_i,
  input wire logic        irq_o,
  input wire logic        wake_o
);
  logic [5:0] idx;
  logic       rdy;
  logic       wtake;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [1:0] en;
  // decoded index, read answer and write take
  assign idx   = avs_address_i[7:2];
  assign rdy   = avs_read_i & ~avs_waitrequest_o;
  assign wtake = avs_write_i & avs_waitrequest_o & avs_byteenable_i[0];
  // mirror of control and enable writes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      c0 <= `DTEU_CTL_RESET;
      c1 <= `DTEU_CTL_RESET;
      en <= 2'h0;
    end else if (wtake) begin
      if (idx == `DTEU_IDX_C0_CTL) begin
        c0 <= avs_writedata_i[7:0];
      end
      if (idx == `DTEU_IDX_C1_CTL) begin
        c1 <= avs_writedata_i[7:0];
      end
      if (idx == `DTEU_IDX_IRQ) begin
        en <= {avs_writedata_i[3], avs_writedata_i[2]};
      end
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // request answered after exactly one wait state
  wait_once_a: assert property ($rose(avs_read_i | avs_write_i)
    |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("wait state count wrong");
  idle_ready_a: assert property (!(avs_read_i | avs_write_i)
    |-> !avs_waitrequest_o) else $error("waitrequest without request");
  rd_upper_a: assert property (
    rdy |-> avs_readdata_o[31:8] == 24'h0) else $error("upper bits set");
  ctl0_back_a: assert property (
    rdy && idx == `DTEU_IDX_C0_CTL && c0[7:6] != 2'h3
    |-> avs_readdata_o[7:0] == (c0 & 8'hD8)) else $error("ctl0 readback");
  ctl1_back_a: assert property (
    rdy && idx == `DTEU_IDX_C1_CTL && c1[7:6] != 2'h3
    |-> avs_readdata_o[7:0] == (c1 & 8'hD8)) else $error("ctl1 readback");
  unmapped_a: assert property (rdy && (idx < 6'h0B || idx > 6'h11)
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  irq_mask_a: assert property (
    irq_o |-> en != 2'h0) else $error("irq with enables clear");
  irq_hold_a: assert property (
    irq_o && !(avs_write_i && idx == `DTEU_IDX_IRQ) |=> irq_o)
    else $error("irq dropped by itself");
  wake_gap_a: assert property (
    wake_o && c0[7:6] != 2'h1 && c1[7:6] != 2'h1 |=> !wake_o [*3])
    else $error("wake pulses too close");
  cover property (rdy && idx == `DTEU_IDX_C1_CTL);
  cover property ($rose(irq_o));
  cover property (wake_o);
endmodule

bind dteu_top dteu_top_props u_dteu_top_props (
  .mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .ext_count_pin_i(ext_count_pin_i), .irq_o(irq_o), .wake_o(wake_o)
);

// File: verif/dteu_core_model.sv
`timescale 1ns/10ps
// ****
// processor core bus master
// ****
module dteu_core_model (
  input  wire logic        mclk_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  output logic      [7:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o
);
  // idle bus at time zero
  initial begin
    address_o    = 8'h00;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0;
    byteenable_o = 4'hF;
  end
  // byte lane enables for the transfers that follow
  task automatic lanes(input logic [3:0] b);
    @(posedge mclk_i);
    byteenable_o <= b;
  endtask
  // one write, held until waitrequest is seen low
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    @(posedge mclk_i);
    address_o   <= {i, 2'h0};
    writedata_o <= {24'h0, d};
    write_o     <= 1'b1;
    do @(posedge mclk_i); while (waitrequest_i !== 1'b0);
    write_o     <= 1'b0;
    writedata_o <= ~writedata_o; // released data does not keep its value
  endtask
  // one read, data taken at the answering edge
  task automatic rd(input logic [5:0] i, output logic [7:0] d);
    @(posedge mclk_i);
    address_o <= {i, 2'h0};
    read_o    <= 1'b1;
    do @(posedge mclk_i); while (waitrequest_i !== 1'b0);
    d = readdata_i[7:0];
    read_o    <= 1'b0;
    address_o <= ~address_o;
  endtask
endmodule

// File: verif/dteu_top_tb.sv
`timescale 1ns/10ps
module dteu_top_tb;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [1:0]  pin = 2'h0;
  logic [7:0]  adr;
  logic        rds, wrs, wreq, irq, wake;
  logic [31:0] wdat, rdat;
  logic [3:0]  be;
  logic [31:0] seed = 32'h00011929;
  logic [15:0] v, r, pre;
  logic [7:0]  d;
  int          num_errors = 0, num_checks = 0, num_wake = 0;
  int          n, k, w, t, w0;
  // ****
  // clock and instances
  // ****
  always #25 mclk_i = ~mclk_i;
  dteu_top u_dteu_top (.mclk_i(mclk_i), .srst_i(srst_i),
    .avs_address_i(adr), .avs_read_i(rds), .avs_write_i(wrs),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .ext_count_pin_i(pin), .irq_o(irq),
    .wake_o(wake));
  dteu_core_model u_dteu_core_model (.mclk_i(mclk_i), .waitrequest_i(wreq),
    .readdata_i(rdat), .address_o(adr), .read_o(rds), .write_o(wrs),
    .writedata_o(wdat), .byteenable_o(be));
  // wake pulse counter
  always @(posedge mclk_i) begin
    if (wake === 1'b1) num_wake <= num_wake + 1;
  end
  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] ix(input int c, input int o);
    return 6'h0C + 6'(3 * c + o);
  endfunction
  function automatic logic [15:0] evt_exp(input int k, input logic e);
    return 16'(e ? k - 1 : k);
  endfunction
  task automatic rnd(output logic [15:0] x);
    seed = lfsr(seed);
    x = seed[15:0];
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] x);
    u_dteu_core_model.wr(i, x);
  endtask
  task automatic rd(input logic [5:0] i, output logic [7:0] x);
    u_dteu_core_model.rd(i, x);
  endtask
  task automatic rdcnt(input int c, output logic [15:0] x);
    logic [7:0] h, l;
    rd(ix(c, 0), h);
    rd(ix(c, 1), l);
    x = {h, l};
  endtask
  task automatic setpin(input int c, input logic lv, input int m);
    pin[c] <= lv;
    repeat (m) @(posedge mclk_i);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, lo, hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    results();
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      rd(ix(c, 2), d);
      chk8(d, 8'h08);
    end
    wr(6'h3F, 8'hFF);
    rd(6'h3F, d);
    chk8(d, 8'h00);
    rd(6'h0B, d);
    chk8(d, 8'h00);
    // write without the low byte lane is ignored
    u_dteu_core_model.lanes(4'hE);
    wr(ix(0, 2), 8'h90);
    u_dteu_core_model.lanes(4'hF);
    rd(ix(0, 2), d);
    chk8(d, 8'h08);
    $display("test reset done");
    for (int c = 0; c < 2; c++) begin
      // preload through the low byte buffer, counter stopped
      rnd(v);
      wr(ix(c, 1), v[7:0]);
      wr(ix(c, 0), v[15:8]);
      wr(ix(c, 1), ~v[7:0]);
      rdcnt(c, r);
      chk_rng(r, v, v);
      // timer overflow, flag, mask and clear
      rnd(v);
      n = 4 + int'(v[3:0]);
      pre = 16'hFFFF - 16'(n);
      wr(ix(c, 1), pre[7:0]);
      wr(ix(c, 0), pre[15:8]);
      wr(6'h0B, 8'h04 << c);
      w0 = num_wake;
      wr(ix(c, 2), 8'hB7);
      t = 0;
      while (irq !== 1'b1) begin
        @(posedge mclk_i);
        t++;
      end
      chk_rng(16'(t), 16'(4 * n - 4), 16'(4 * n + 12));
      rd(6'h0B, d);
      chk8(d, 8'h24 << c);
      chk8(8'(num_wake > w0), 8'h01);
      rd(ix(c, 2), d);
      chk8(d, 8'h90);
      wr(6'h0B, 8'h00);
      repeat (4 * n + 16) @(posedge mclk_i);
      chk8({7'h0, irq}, 8'h00);
      rd(6'h0B, d);
      chk8(d, 8'h20 << c);
      wr(ix(c, 2), 8'h80);
      wr(6'h0B, 8'h00);
      rd(6'h0B, d);
      chk8(d, 8'h00);
      // event counting on either edge, pin returned low at the end
      for (int e = 0; e < 2; e++) begin
        rnd(v);
        k = 2 + int'(v[2:0]);
        wr(ix(c, 1), 8'h00);
        wr(ix(c, 0), 8'h00);
        wr(ix(c, 2), {4'h5, e[0], 3'h0});
        setpin(c, 1'b1, 8);
        repeat (k - 1) begin
          setpin(c, 1'b0, 8);
          setpin(c, 1'b1, 8);
        end
        wr(ix(c, 2), {4'h4, e[0], 3'h0});
        rdcnt(c, r);
        chk_rng(r, evt_exp(k, e[0]), evt_exp(k, e[0]));
        setpin(c, 1'b0, 8);
      end
      // one pulse measured, a second one ignored, then idle mode
      wr(ix(c, 1), 8'h00);
      wr(ix(c, 0), 8'h00);
      rnd(v);
      w = 40 + int'(v[4:0]);
      wr(ix(c, 2), 8'hD0);
      setpin(c, 1'b1, w);
      setpin(c, 1'b0, 16);
      rd(ix(c, 2), d);
      chk8(d, 8'hC0);
      setpin(c, 1'b1, w + 40);
      setpin(c, 1'b0, 16);
      rdcnt(c, r);
      chk_rng(r, 16'(w / 4 - 2), 16'(w / 4 + 2));
      wr(ix(c, 2), 8'h10);
      repeat (40) @(posedge mclk_i);
      wr(ix(c, 2), 8'h00);
      rdcnt(c, v);
      chk_rng(v, r, r);
      $display("test channel %0d done", c);
    end
    results();
  end
endmodule
